//--- verilog/gic_pkg.sv
package gic_pkg;
  localparam int          GIC_NPINS      = 4;
  localparam int          GIC_DEB_TICKS  = 4;
  // register addresses
  localparam logic [14:0] GIC_ADDR_CFG   = 15'h000b;
  localparam logic [14:0] GIC_ADDR_PIN1  = 15'h000c;
  localparam logic [14:0] GIC_ADDR_PIN4  = 15'h000f;
  localparam logic [14:0] GIC_ADDR_STAT  = 15'h0010;
  localparam logic [14:0] GIC_ADDR_IRQC  = 15'h0012;
  localparam logic [14:0] GIC_ADDR_MASK  = 15'h0013;
  // pin setup field positions
  localparam int          GIC_DIR_BIT    = 15;
  localparam int          GIC_PULL_LO    = 13;
  localparam int          GIC_EDGE_BIT   = 12;
  localparam int          GIC_POL_BIT    = 10;
  localparam int          GIC_LVL_BIT    = 5;
  localparam logic [15:0] GIC_PIN_WMASK  = 16'hf42f;
  localparam logic [15:0] GIC_PIN_RST    = 16'h8000;
  localparam logic [15:0] GIC_PIN3_RST   = 16'hc000;
  localparam int          GIC_SHARED_PIN = 2;
  // status and mask layout
  localparam int          GIC_TEMP_BIT   = 15;
  localparam int          GIC_PINF_LO    = 11;
  localparam int          GIC_UV_BIT     = 0;
  localparam logic [15:0] GIC_STAT_MASK  = 16'hf801;
  localparam logic [15:0] GIC_STAT_RST   = 16'h0000;
  localparam logic [15:0] GIC_MASK_RST   = 16'h0000;
  localparam logic        GIC_GMASK_RST  = 1'b1;
  // function codes
  localparam logic [3:0]  GIC_FN_LVL_IN  = 4'h0;
  localparam logic [3:0]  GIC_FN_EDGE_IN = 4'h1;
  localparam logic [3:0]  GIC_FN_DIVCLK  = 4'h2;
  localparam logic [3:0]  GIC_FN_IRQ     = 4'h3;
  localparam logic [3:0]  GIC_FN_TEMP    = 4'h7;
  localparam logic [3:0]  GIC_FN_MICCLK  = 4'h9;
  localparam logic [3:0]  GIC_FN_LVL_OUT = 4'ha;
  localparam logic [3:0]  GIC_FN_UV      = 4'hb;
endpackage

//--- verilog/gic_debounce.sv
`timescale 1ns/1ps
`default_nettype none
module gic_debounce
  import gic_pkg::*;
#(
  parameter int TICKS = GIC_DEB_TICKS
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic ce_in,
  input  wire logic tick_in,
  input  wire logic raw_in,
  output logic      clean_out
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       next_clean;

  // level must hold for TICKS timeout ticks before it is accepted
  always_comb begin
    next_cnt   = cnt;
    next_clean = clean_out;
    if (raw_in == clean_out) begin
      next_cnt = 8'h00;
    end else if (tick_in) begin
      if (cnt == 8'(TICKS - 1)) begin
        next_clean = raw_in;
        next_cnt   = 8'h00;
      end else begin
        next_cnt = cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt       <= 8'h00;
      clean_out <= 1'b0;
    end else if (ce_in) begin
      cnt       <= next_cnt;
      clean_out <= next_clean;
    end
  end
endmodule
`default_nettype wire

//--- verilog/gic_pin.sv
`timescale 1ns/1ps
`default_nettype none
module gic_pin
  import gic_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  input  wire logic [15:0] setup_in,
  input  wire logic        allow_in,
  input  wire logic        clean_in,
  input  wire logic        irq_in,
  input  wire logic        divclk_in,
  input  wire logic        micclk_in,
  input  wire logic        temp_in,
  input  wire logic        uv_in,
  output logic             event_out,
  output logic             data_out,
  output logic             oe_out
);
  logic [3:0] fn;
  logic       pol;
  logic       prev;
  logic       act;
  logic       src;
  logic       drive;
  logic       next_data;
  logic       next_oe;

  assign fn  = setup_in[3:0];
  assign pol = setup_in[GIC_POL_BIT];
  assign act = clean_in ^ pol;

  always_comb begin
    event_out = 1'b0;
    src       = 1'b0;
    drive     = 1'b1;
    case (fn)
      GIC_FN_LVL_IN:  begin drive = 1'b0; event_out = act; end
      GIC_FN_EDGE_IN: begin
        drive = 1'b0;
        if (setup_in[GIC_EDGE_BIT]) begin
          event_out = clean_in ^ prev;
        end else begin
          event_out = act & ~(prev ^ pol);
        end
      end
      GIC_FN_DIVCLK:  src = divclk_in;
      GIC_FN_MICCLK:  src = micclk_in;
      GIC_FN_IRQ:     src = irq_in;
      GIC_FN_TEMP:    src = temp_in;
      GIC_FN_UV:      src = uv_in;
      GIC_FN_LVL_OUT: src = setup_in[GIC_LVL_BIT];
      default:        drive = 1'b0;
    endcase
    if (!allow_in) begin
      event_out = 1'b0;
    end
    next_data = src ^ pol;
    next_oe   = drive & allow_in & ~setup_in[GIC_DIR_BIT];
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prev     <= 1'b0;
      data_out <= 1'b0;
      oe_out   <= 1'b0;
    end else if (ce_in) begin
      prev     <= clean_in;
      data_out <= next_data;
      oe_out   <= next_oe;
    end
  end
endmodule
`default_nettype wire

//--- verilog/gic_top.sv
`timescale 1ns/1ps
`default_nettype none
module gic_top
  import gic_pkg::*;
#(
  parameter int NPINS     = GIC_NPINS,
  parameter int DEB_TICKS = GIC_DEB_TICKS
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  input  wire logic             reg_wr_en_in,
  input  wire logic             reg_rd_en_in,
  input  wire logic [14:0]      reg_addr_in,
  input  wire logic [15:0]      reg_wdata_in,
  output logic      [15:0]      reg_rdata_out,
  input  wire logic [NPINS-1:0] pin_in,
  output logic      [NPINS-1:0] pin_data_out,
  output logic      [NPINS-1:0] pin_oe_out,
  output logic  [2*NPINS-1:0]   pin_pull_out,
  input  wire logic             timeout_tick_in,
  input  wire logic             timeout_clock_enable_in,
  input  wire logic             oscillator_clock_enable_in,
  input  wire logic             divided_clock_in,
  input  wire logic             mic_clock_in,
  input  wire logic             overtemp_status_in,
  input  wire logic             regulator_undervolt_status_in,
  output logic                  irq_out,
  output logic                  control_port_select_out
);
  logic [15:0]      setup      [NPINS];
  logic [15:0]      next_setup [NPINS];
  logic             release_bit;
  logic             next_release;
  logic             cps;
  logic             next_cps;
  logic [15:0]      status;
  logic [15:0]      next_status;
  logic [15:0]      mask;
  logic [15:0]      next_mask;
  logic             gmask;
  logic             next_gmask;
  logic             next_irq;
  logic [15:0]      next_rdata;
  logic [15:0]      set_bits;
  logic [NPINS-1:0] clean;
  logic [NPINS-1:0] pin_evt;
  logic [NPINS-1:0] allow;
  logic             tick;
  logic             rd_stat;

  // debounce only advances while the timeout clock really runs
  assign tick = timeout_tick_in & timeout_clock_enable_in & oscillator_clock_enable_in;
  assign rd_stat = reg_rd_en_in && (reg_addr_in == GIC_ADDR_STAT);

  ////////////////////////////////////////////////////////////////////////////
  // per-pin datapath

  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : pin_g
      assign allow[g] = (g != GIC_SHARED_PIN) || release_bit;
      assign pin_pull_out[2*g +: 2] = setup[g][GIC_PULL_LO +: 2];
      gic_debounce #(.TICKS(DEB_TICKS)) u_deb (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .ce_in     (ce_in),
        .tick_in   (tick),
        .raw_in    (pin_in[g]),
        .clean_out (clean[g])
      );
      gic_pin u_pin (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .ce_in     (ce_in),
        .setup_in  (setup[g]),
        .allow_in  (allow[g]),
        .clean_in  (clean[g]),
        .irq_in    (irq_out),
        .divclk_in (divided_clock_in),
        .micclk_in (mic_clock_in),
        .temp_in   (overtemp_status_in),
        .uv_in     (regulator_undervolt_status_in),
        .event_out (pin_evt[g]),
        .data_out  (pin_data_out[g]),
        .oe_out    (pin_oe_out[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // register file and interrupt controller

  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      next_setup[i] = setup[i];
      if (reg_wr_en_in && (reg_addr_in == GIC_ADDR_PIN1 + 15'(i))) begin
        next_setup[i] = reg_wdata_in & GIC_PIN_WMASK;
      end
    end
    next_release = release_bit;
    if (reg_wr_en_in && (reg_addr_in == GIC_ADDR_CFG) && reg_wdata_in[0]) begin
      next_release = 1'b1;
    end
    next_cps = release_bit ? cps : pin_in[GIC_SHARED_PIN];
    next_mask = mask;
    if (reg_wr_en_in && (reg_addr_in == GIC_ADDR_MASK)) begin
      next_mask = reg_wdata_in & GIC_STAT_MASK;
    end
    next_gmask = gmask;
    if (reg_wr_en_in && (reg_addr_in == GIC_ADDR_IRQC)) begin
      next_gmask = reg_wdata_in[0];
    end
    set_bits = 16'h0000;
    set_bits[GIC_TEMP_BIT] = overtemp_status_in;
    set_bits[GIC_PINF_LO +: NPINS] = pin_evt;
    set_bits[GIC_UV_BIT] = regulator_undervolt_status_in;
    // a source active in the read cycle sets again, so it wins over the clear
    next_status = (rd_stat ? GIC_STAT_RST : status) | set_bits;
    next_irq = (|(next_status & ~next_mask)) & ~next_gmask;
    next_rdata = 16'h0000;
    if (reg_rd_en_in) begin
      if (reg_addr_in == GIC_ADDR_CFG) begin
        next_rdata = {15'h0000, release_bit};
      end else if (reg_addr_in == GIC_ADDR_STAT) begin
        next_rdata = status;
      end else if (reg_addr_in == GIC_ADDR_IRQC) begin
        next_rdata = {15'h0000, gmask};
      end else if (reg_addr_in == GIC_ADDR_MASK) begin
        next_rdata = mask;
      end else begin
        for (int i = 0; i < NPINS; i++) begin
          if (reg_addr_in == GIC_ADDR_PIN1 + 15'(i)) begin
            next_rdata = setup[i];
            next_rdata[GIC_LVL_BIT] = pin_in[i] ^ setup[i][GIC_POL_BIT];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NPINS; i++) begin
        setup[i] <= (i == GIC_SHARED_PIN) ? GIC_PIN3_RST : GIC_PIN_RST;
      end
      release_bit             <= 1'b0;
      cps                     <= 1'b0;
      status                  <= GIC_STAT_RST;
      mask                    <= GIC_MASK_RST;
      gmask                   <= GIC_GMASK_RST;
      irq_out                 <= 1'b0;
      reg_rdata_out           <= 16'h0000;
      control_port_select_out <= 1'b0;
    end else if (ce_in) begin
      for (int i = 0; i < NPINS; i++) begin
        setup[i] <= next_setup[i];
      end
      release_bit             <= next_release;
      cps                     <= next_cps;
      status                  <= next_status;
      mask                    <= next_mask;
      gmask                   <= next_gmask;
      irq_out                 <= next_irq;
      reg_rdata_out           <= next_rdata;
      control_port_select_out <= next_cps;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  reset_values_a: assert property (!$past(rst_n_in) |->
    setup[0][GIC_DIR_BIT] && setup[3][GIC_DIR_BIT] && setup[2] == GIC_PIN3_RST && gmask)
    else $error("reset values wrong");
  status_sticky_a: assert property (status[GIC_UV_BIT] && !(ce_in && rd_stat) |=>
    status[GIC_UV_BIT])
    else $error("status flag lost without read");
  status_clear_a: assert property (ce_in && rd_stat && !regulator_undervolt_status_in |=>
    !status[GIC_UV_BIT])
    else $error("status flag not cleared by read");
  status_persist_a: assert property (ce_in && rd_stat && overtemp_status_in |=>
    status[GIC_TEMP_BIT] && reg_rdata_out[GIC_TEMP_BIT] == $past(status[GIC_TEMP_BIT]))
    else $error("persisting source lost on read");
  irq_or_a: assert property (irq_out == ((|(status & ~mask)) & ~gmask))
    else $error("interrupt output not OR of unmasked flags");
  uv_mask_a: assert property (mask[GIC_UV_BIT] && status[GIC_UV_BIT] &&
    ((status & ~mask) == 16'h0000) |-> !irq_out)
    else $error("masked source reached interrupt output");
  release_latch_a: assert property (release_bit |=> release_bit)
    else $error("release bit dropped");
  reserved_quiet_a: assert property (ce_in && setup[0][3:0] == 4'h5 |->
    !pin_evt[0] ##1 !pin_oe_out[0])
    else $error("reserved function drives pin");
  level_out_a: assert property (ce_in && setup[0][3:0] == GIC_FN_LVL_OUT &&
    !setup[0][GIC_DIR_BIT] |=> pin_oe_out[0] &&
    pin_data_out[0] == ($past(setup[0][GIC_LVL_BIT]) ^ $past(setup[0][GIC_POL_BIT])))
    else $error("level output wrong");
  temp_out_a: assert property (ce_in && setup[0][3:0] == GIC_FN_TEMP &&
    !setup[0][GIC_POL_BIT] |=> pin_data_out[0] == $past(overtemp_status_in))
    else $error("temperature output wrong");
  irq_pin_a: assert property (ce_in && setup[0][3:0] == GIC_FN_IRQ &&
    !setup[0][GIC_DIR_BIT] |=> pin_oe_out[0] &&
    pin_data_out[0] == ($past(irq_out) ^ $past(setup[0][GIC_POL_BIT])))
    else $error("interrupt pin output wrong");
  divclk_pin_a: assert property (ce_in && setup[0][3:0] == GIC_FN_DIVCLK &&
    !setup[0][GIC_DIR_BIT] |=> pin_oe_out[0] &&
    pin_data_out[0] == ($past(divided_clock_in) ^ $past(setup[0][GIC_POL_BIT])))
    else $error("divided clock output wrong");
  micclk_pin_a: assert property (ce_in && setup[0][3:0] == GIC_FN_MICCLK &&
    !setup[0][GIC_DIR_BIT] |=> pin_oe_out[0] &&
    pin_data_out[0] == ($past(mic_clock_in) ^ $past(setup[0][GIC_POL_BIT])))
    else $error("mic clock output wrong");
  uv_pin_a: assert property (ce_in && setup[0][3:0] == GIC_FN_UV &&
    !setup[0][GIC_POL_BIT] |=> pin_data_out[0] == $past(regulator_undervolt_status_in))
    else $error("undervoltage output wrong");
  dir_input_a: assert property (ce_in && setup[0][GIC_DIR_BIT] |=> !pin_oe_out[0])
    else $error("input pin drives");
  pull_map_a: assert property (pin_pull_out == {setup[3][GIC_PULL_LO +: 2],
    setup[2][GIC_PULL_LO +: 2], setup[1][GIC_PULL_LO +: 2], setup[0][GIC_PULL_LO +: 2]})
    else $error("pull field not on pins");
  setup_bits_a: assert property ((setup[0] & ~GIC_PIN_WMASK) == 16'h0000)
    else $error("pin setup holds an unused bit");
  lvl_read_a: assert property (ce_in && reg_rd_en_in && reg_addr_in == GIC_ADDR_PIN4 |=>
    reg_rdata_out[GIC_LVL_BIT] == ($past(pin_in[3]) ^ $past(setup[3][GIC_POL_BIT])))
    else $error("level bit read wrong");
  reset_outputs_a: assert property (!$past(rst_n_in) |-> !irq_out &&
    reg_rdata_out == 16'h0000 && pin_oe_out == '0 && !control_port_select_out)
    else $error("outputs not cleared by reset");

  // flags, events and the shared pin
  temp_flag_a: assert property (ce_in && overtemp_status_in |=> status[GIC_TEMP_BIT])
    else $error("thermal flag not set");
  uv_flag_a: assert property (ce_in && regulator_undervolt_status_in |=>
    status[GIC_UV_BIT])
    else $error("undervoltage flag not set");
  masked_flag_a: assert property (ce_in && mask[GIC_UV_BIT] &&
    regulator_undervolt_status_in |=> status[GIC_UV_BIT])
    else $error("masked source did not set its flag");
  flags_sticky_a: assert property (ce_in && !rd_stat |=>
    (status & $past(status)) == $past(status))
    else $error("status flag dropped without read");
  flag_layout_a: assert property ((status & ~GIC_STAT_MASK) == 16'h0000)
    else $error("status bit outside the layout");
  gmask_quiet_a: assert property (gmask |-> !irq_out)
    else $error("globally masked output raised");
  irq_hold_a: assert property (ce_in && irq_out && !rd_stat && !reg_wr_en_in |=>
    irq_out)
    else $error("interrupt output dropped without read");
  level_evt_a: assert property (ce_in && setup[3][3:0] == GIC_FN_LVL_IN &&
    (clean[3] ^ setup[3][GIC_POL_BIT]) |=> status[GIC_PINF_LO + 3])
    else $error("level input flag not held");
  edge_evt_a: assert property (setup[1][3:0] == GIC_FN_EDGE_IN &&
    setup[1][GIC_EDGE_BIT] && $changed(clean[1]) |-> pin_evt[1])
    else $error("both-edge event missed");
  rise_evt_a: assert property (setup[1][3:0] == GIC_FN_EDGE_IN &&
    !setup[1][GIC_EDGE_BIT] && !setup[1][GIC_POL_BIT] && $rose(clean[1]) |-> pin_evt[1])
    else $error("rising edge event missed");
  fall_evt_a: assert property (setup[1][3:0] == GIC_FN_EDGE_IN &&
    !setup[1][GIC_EDGE_BIT] && setup[1][GIC_POL_BIT] && $fell(clean[1]) |-> pin_evt[1])
    else $error("falling edge event missed");
  shared_quiet_a: assert property (!release_bit |-> !pin_evt[GIC_SHARED_PIN] &&
    !pin_oe_out[GIC_SHARED_PIN])
    else $error("shared pin active before release");
  cps_frozen_a: assert property (release_bit |=> $stable(control_port_select_out))
    else $error("control port select moved after release");
  release_wr_a: assert property (ce_in && reg_wr_en_in && reg_addr_in == GIC_ADDR_CFG &&
    reg_wdata_in[0] |=> release_bit)
    else $error("release bit not set by write");
  deb_hold_a: assert property (!tick |=> $stable(clean))
    else $error("debounce moved without timeout tick");

  irq_rise_c: cover property ($rose(irq_out));
  edge_evt_c: cover property (setup[1][3:0] == GIC_FN_EDGE_IN && pin_evt[1]);
  read_clear_c: cover property (rd_stat && ce_in && status != 16'h0000 ##1 status == 16'h0000);
  level_hold_c: cover property (setup[3][3:0] == GIC_FN_LVL_IN && pin_evt[3] ##1 pin_evt[3]);
  release_c: cover property ($rose(release_bit));
endmodule
`default_nettype wire

//--- dv/gic_ext_model.sv
`timescale 1ns/1ps
`default_nettype none
module gic_ext_model
  import gic_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic [3:0] data_in,
  input  wire logic [3:0] oe_in,
  input  wire logic [3:0] drv_in,
  input  wire logic [3:0] lvl_in,
  input  wire logic [7:0] pull_in,
  output logic      [3:0] pad_out,
  output logic            tick_out
);
  logic [3:0] last_q = 4'h0;
  logic       tick_q = 1'b0;
  // wire level: device drive, then outside driver, then pull, else floats to the inverse of last value
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (oe_in[i]) begin
        pad_out[i] = data_in[i];
      end else if (drv_in[i]) begin
        pad_out[i] = lvl_in[i];
      end else begin
        case (pull_in[2*i +: 2])
          2'b10:   pad_out[i] = 1'b1;
          2'b01:   pad_out[i] = 1'b0;
          default: pad_out[i] = ~last_q[i];
        endcase
      end
    end
  end
  // timeout clock source, one tick every second cycle
  always_ff @(posedge clk_in) begin
    last_q <= pad_out;
    tick_q <= ~tick_q;
  end
  assign tick_out = tick_q;
endmodule
`default_nettype wire

//--- dv/test_gic_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module test_gic_top
  import gic_pkg::*;
;
  logic        clk_in, rst_n_in, wr_en, rd_en, tick, to_en, osc_en;
  logic        divclk, micclk, temp, uv, irq, cps, ce;
  logic [14:0] addr;
  logic [15:0] wdata, rdata;
  logic [3:0]  pad, pdata, poe, ext_drv, ext_lvl;
  logic [7:0]  ppull;
  int          mismatches = 0;
  int          checks_done = 0;
  logic [3:0]  fc [14] = '{4'h2, 4'h9, 4'h7, 4'hb, 4'ha, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8,
                            4'hc, 4'hd, 4'he, 4'hf};
  logic [5:0]  exd = 6'b01_0101;

  gic_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce), .reg_wr_en_in(wr_en),
    .reg_rd_en_in(rd_en), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .pin_in(pad), .pin_data_out(pdata), .pin_oe_out(poe), .pin_pull_out(ppull),
    .timeout_tick_in(tick), .timeout_clock_enable_in(to_en),
    .oscillator_clock_enable_in(osc_en), .divided_clock_in(divclk), .mic_clock_in(micclk),
    .overtemp_status_in(temp), .regulator_undervolt_status_in(uv), .irq_out(irq),
    .control_port_select_out(cps));
  gic_ext_model ext (.clk_in(clk_in), .data_in(pdata), .oe_in(poe), .drv_in(ext_drv),
    .lvl_in(ext_lvl), .pull_in(ppull), .pad_out(pad), .tick_out(tick));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (mismatches == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [14:0] a, input logic [15:0] d);
    @(negedge clk_in);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk_in);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [14:0] a, input logic [15:0] e);
    @(negedge clk_in);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk_in);
    rd_en = 1'b0;
    `CHK(rdata, e)
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic pulse_src(input int which);
    @(negedge clk_in);
    if (which == 0) temp = 1'b1; else uv = 1'b1;
    @(negedge clk_in);
    temp = 1'b0;
    uv = 1'b0;
    wt(2);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    print_verdict();
  end
  initial begin
    {wr_en, rd_en, to_en, osc_en, divclk, micclk, temp, uv} = 8'h00;
    ce = 1'b1;
    addr = 15'h0000;
    wdata = 16'h0000;
    ext_drv = 4'hf;
    ext_lvl = 4'h0;
    rst_n_in = 1'b0;
    repeat (20) @(negedge clk_in);
    rst_n_in = 1'b1;
    rd(GIC_ADDR_PIN1, 16'h8000);
    rd(15'h000d, 16'h8000);
    rd(15'h000e, 16'hc000);
    rd(GIC_ADDR_PIN4, 16'h8000);
    rd(GIC_ADDR_STAT, 16'h0000);
    rd(GIC_ADDR_IRQC, 16'h0001);
    rd(GIC_ADDR_MASK, 16'h0000);
    rd(15'h0011, 16'h0000);
    `CHK(ppull, 8'h20)
    ext_lvl[2] = 1'b1;
    wt(3);
    `CHK(cps, 1'b1)
    wr(GIC_ADDR_CFG, 16'h0001);
    ext_lvl[2] = 1'b0;
    wt(3);
    `CHK(cps, 1'b1)
    wr(GIC_ADDR_PIN1, 16'hffff);
    rd(GIC_ADDR_PIN1, 16'hf42f);
    `CHK(poe[0], 1'b0)
    divclk = 1'b1;
    temp = 1'b1;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 14; i++) begin
        wr(GIC_ADDR_PIN1, 16'h0020 | (16'(p) << 10) | 16'(fc[i]));
        wt(3);
        `CHK(poe[0], 1'(i < 6))
        if (i < 6) `CHK(pdata[0], exd[i] ^ 1'(p))
      end
    end
    temp = 1'b0;
    wr(GIC_ADDR_PIN1, 16'h802a);
    wt(3);
    `CHK(poe[0], 1'b0)
    wr(GIC_ADDR_PIN1, 16'h8000);
    rd(GIC_ADDR_STAT, 16'h8000);
    to_en = 1'b1;
    osc_en = 1'b1;
    wr(GIC_ADDR_IRQC, 16'h0000);
    pulse_src(0);
    `CHK(irq, 1'b1)
    rd(GIC_ADDR_STAT, 16'h8000);
    `CHK(irq, 1'b0)
    rd(GIC_ADDR_STAT, 16'h0000);
    wr(GIC_ADDR_MASK, 16'h8001);
    pulse_src(0);
    pulse_src(1);
    `CHK(irq, 1'b0)
    rd(GIC_ADDR_STAT, 16'h8001);
    wr(GIC_ADDR_MASK, 16'h0000);
    temp = 1'b1;
    wt(2);
    rd(GIC_ADDR_STAT, 16'h8000);
    `CHK(irq, 1'b1)
    temp = 1'b0;
    rd(GIC_ADDR_STAT, 16'h8000);
    rd(GIC_ADDR_STAT, 16'h0000);
    wr(GIC_ADDR_IRQC, 16'h0001);
    pulse_src(1);
    `CHK(irq, 1'b0)
    rd(GIC_ADDR_STAT, 16'h0001);
    wr(GIC_ADDR_IRQC, 16'h0000);
    wr(15'h000d, 16'h8001);
    ext_lvl[1] = 1'b1;
    wt(20);
    rd(GIC_ADDR_STAT, 16'h1000);
    rd(GIC_ADDR_STAT, 16'h0000);
    ext_lvl[1] = 1'b0;
    wt(20);
    rd(GIC_ADDR_STAT, 16'h0000);
    wr(15'h000d, 16'h9001);
    ext_lvl[1] = 1'b1;
    wt(20);
    rd(GIC_ADDR_STAT, 16'h1000);
    wr(15'h000d, 16'h8401);
    ext_lvl[1] = 1'b0;
    wt(20);
    rd(GIC_ADDR_STAT, 16'h1000);
    osc_en = 1'b0;
    ext_lvl[3] = 1'b1;
    wt(20);
    rd(GIC_ADDR_STAT, 16'h0000);
    rd(GIC_ADDR_PIN4, 16'h8020);
    osc_en = 1'b1;
    wt(20);
    rd(GIC_ADDR_STAT, 16'h4000);
    rd(GIC_ADDR_STAT, 16'h4000);
    ext_lvl[3] = 1'b0;
    wt(20);
    rd(GIC_ADDR_STAT, 16'h4000);
    rd(GIC_ADDR_STAT, 16'h0000);
    ce = 1'b0;
    pulse_src(0);
    ce = 1'b1;
    rd(GIC_ADDR_STAT, 16'h0000);
    `CHK(irq, 1'b0)
    print_verdict();
  end
endmodule
`default_nettype wire
